// ---- common/rtcocw_defs.svh ----
// Register offsets, field positions and timing constants for the RTC support block.
`ifndef RTCOCW_DEFS_SVH
`define RTCOCW_DEFS_SVH
`define RTCOCW_REG_FLAGS     4'h0
`define RTCOCW_REG_ALM_SEC   4'h2
`define RTCOCW_REG_ALM_MIN   4'h3
`define RTCOCW_REG_ALM_HOUR  4'h4
`define RTCOCW_REG_ALM_DATE  4'h5
`define RTCOCW_REG_IRQ_CTRL  4'h6
`define RTCOCW_REG_WD_CTRL   4'h7
`define RTCOCW_REG_TRIM      4'h8
// Flags register bit positions.
`define RTCOCW_FLG_WR_UNLOCK 1
`define RTCOCW_FLG_CAL_OUT   2
`define RTCOCW_FLG_OSC_FAIL  5
`define RTCOCW_FLG_ALARM     6
`define RTCOCW_FLG_WD        7
// Interrupt control bit positions.
`define RTCOCW_IRQ_SQ_LO     0
`define RTCOCW_IRQ_SQ_HI     1
`define RTCOCW_IRQ_SQ_EN     6
`define RTCOCW_IRQ_WD_EN     7
`define RTCOCW_IRQ_ALM_EN    5
// Watchdog control bit positions.
`define RTCOCW_WD_STROBE     7
`define RTCOCW_WD_LOCK       6
// Trim register bit positions.
`define RTCOCW_TRIM_SIGN     5
`define RTCOCW_TRIM_OSC_DIS  7
// Alarm field match bit.
`define RTCOCW_ALM_MATCH     7
// Oscillator divider taps for 4096 Hz, 512 Hz, 32 Hz and 1 Hz; 32768 Hz is the tick itself.
`define RTCOCW_TAP_4096      2
`define RTCOCW_TAP_512       5
`define RTCOCW_TAP_32        9
`define RTCOCW_TAP_1         14
`define RTCOCW_DIV_W         15
`define RTCOCW_CAL_SHORT     15'h0080
`define RTCOCW_CAL_LONG      15'h0100
`define RTCOCW_OSC_FAIL_MS   5
`define RTCOCW_CLK_KHZ       50000
`define RTCOCW_OSC_START_S   2
`define RTCOCW_MIN_SECS      6'h3b
`define RTCOCW_CYC_MINS      6'h3f
`endif

// ---- common/rtcocw_pkg.sv ----
// Types shared by the RTC support block.
package rtcocw_pkg;
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
    } rtcocw_time_s;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] data;
    } rtcocw_req_s;
    typedef enum logic [1:0] {
        RTCOCW_SQ_1HZ,
        RTCOCW_SQ_512HZ,
        RTCOCW_SQ_4096HZ,
        RTCOCW_SQ_32KHZ
    } rtcocw_sq_e;
endpackage : rtcocw_pkg

// ---- hw/rtcocw_top.sv ----
// Oscillator control, trim, alarm, watchdog and interrupt pin source of the RTC.
`timescale 1ns/1ns
`include "rtcocw_defs.svh"
module rtcocw_top #(
    parameter int          OSC_FAIL_CYC = `RTCOCW_OSC_FAIL_MS * `RTCOCW_CLK_KHZ,
    parameter int          OSC_START_CYC = `RTCOCW_OSC_START_S * `RTCOCW_CLK_KHZ * 1000,
    parameter logic [7:0]  TRIM_RESET   = 8'h00
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_nrst,
    input  wire logic                 i_ce,
    input  wire rtcocw_pkg::rtcocw_req_s i_req,
    input  wire logic                 i_osc_tick,
    input  wire logic                 i_on_backup,
    input  wire rtcocw_pkg::rtcocw_time_s i_now,
    output logic [7:0]                o_rdata,
    output logic                      o_osc_run,
    output logic                      o_osc_stable,
    output logic                      o_base_reload,
    output logic [14:0]               o_trim_adjust,
    output logic                      o_trim_sign,
    output logic                      o_int_level,
    output logic                      o_int_oe
);
    import rtcocw_pkg::*;
    // Refuse counts that the 32-bit power-up and start-up timers cannot serve.
    if (OSC_FAIL_CYC < 1 || OSC_START_CYC < 1) begin : g_bad_counts
        $error("rtcocw_top: counts must be positive");
    end
    logic rst_s1_ff, rst_n;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end
    logic [7:0] flags_ff, irq_ff, wd_ff, trim_ff;
    rtcocw_time_s alm_sh_ff, alm_ff;
    logic wr_flags, rd_flags, unlock_fall;
    assign wr_flags = i_ce && i_req.wr && i_req.addr == `RTCOCW_REG_FLAGS;
    assign rd_flags = i_ce && i_req.rd && i_req.addr == `RTCOCW_REG_FLAGS;
    assign unlock_fall = wr_flags && flags_ff[`RTCOCW_FLG_WR_UNLOCK]
                         && !i_req.data[`RTCOCW_FLG_WR_UNLOCK];
    function automatic logic wr_at(input rtcocw_req_s r, input logic [3:0] a);
        wr_at = r.wr && r.addr == a;
    endfunction : wr_at
    logic osc_en;
    assign osc_en = !trim_ff[`RTCOCW_TRIM_OSC_DIS];
    assign o_osc_run = osc_en;
    logic tick;
    assign tick = i_osc_tick && osc_en;
    // Oscillator start-up timer: stable after the start time once enabled, or at once if a tick arrives while the timer is still zero.
    logic [31:0] start_ff;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            start_ff <= 32'h0;
        end else if (i_ce) begin
            if (!osc_en) start_ff <= 32'h0;
            else if (start_ff < OSC_START_CYC[31:0]) start_ff <= start_ff + 32'h1;
        end
    end
    assign o_osc_stable = osc_en && (start_ff >= OSC_START_CYC[31:0] || start_ff == 32'h0 && tick);
    // Power-up activity check of the oscillator.
    logic [31:0] pu_ff;
    logic pu_seen_ff, pu_done_ff, fail_set;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            pu_ff      <= 32'h0;
            pu_seen_ff <= 1'b0;
            pu_done_ff <= 1'b0;
        end else if (i_ce && !pu_done_ff) begin
            pu_ff <= pu_ff + 32'h1;
            if (tick) pu_seen_ff <= 1'b1;
            if (pu_ff == OSC_FAIL_CYC[31:0] - 32'h1) pu_done_ff <= 1'b1;
        end
    end
    assign fail_set = i_ce && !pu_done_ff && pu_ff == OSC_FAIL_CYC[31:0] - 32'h1
                      && osc_en && !pu_seen_ff && !tick;
    assign o_base_reload = fail_set;
    // Binary divider of the oscillator ticks.
    logic [`RTCOCW_DIV_W-1:0] div_ff;
    logic [5:0] sec_ff, min_ff;
    logic adj_sec;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= '0;
        end else if (i_ce && tick) begin
            div_ff <= div_ff + 15'h1;
        end
    end
    logic sec_tick;
    assign sec_tick = tick && &div_ff;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            sec_ff <= 6'h0;
            min_ff <= 6'h0;
        end else if (i_ce && sec_tick) begin
            sec_ff <= (sec_ff == `RTCOCW_MIN_SECS) ? 6'h0 : sec_ff + 6'h1;
            if (sec_ff == `RTCOCW_MIN_SECS) min_ff <= (min_ff == `RTCOCW_CYC_MINS) ? 6'h0 : min_ff + 6'h1;
        end
    end
    assign adj_sec = sec_ff == 6'h0 && {1'b0, min_ff} < {1'b0, trim_ff[4:0], 1'b0};
    assign o_trim_sign   = trim_ff[`RTCOCW_TRIM_SIGN];
    assign o_trim_adjust = !adj_sec ? 15'h0 : (trim_ff[`RTCOCW_TRIM_SIGN] ? `RTCOCW_CAL_LONG : `RTCOCW_CAL_SHORT);
    // Register writes.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            trim_ff <= 8'h00;
            irq_ff  <= 8'h00;
        end else if (i_ce) begin
            if (wr_at(i_req, `RTCOCW_REG_TRIM)) trim_ff <= {i_req.data[7], 1'b0, i_req.data[5:0]};
            if (wr_at(i_req, `RTCOCW_REG_IRQ_CTRL)) irq_ff <= i_req.data;
        end
    end
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            alm_sh_ff <= '1;
            alm_ff    <= '1;
        end else if (i_ce) begin
            if (wr_at(i_req, `RTCOCW_REG_ALM_SEC))  alm_sh_ff.sec  <= i_req.data;
            if (wr_at(i_req, `RTCOCW_REG_ALM_MIN))  alm_sh_ff.min  <= i_req.data;
            if (wr_at(i_req, `RTCOCW_REG_ALM_HOUR)) alm_sh_ff.hour <= i_req.data;
            if (wr_at(i_req, `RTCOCW_REG_ALM_DATE)) alm_sh_ff.date <= i_req.data;
            if (unlock_fall) alm_ff <= alm_sh_ff;
        end
    end
    // Alarm comparator, one field per generate slice.
    logic [3:0] fld_ok, fld_used;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_alm
            assign fld_used[g] = !alm_ff[g*8+`RTCOCW_ALM_MATCH];
            assign fld_ok[g]   = !fld_used[g] || alm_ff[g*8+6:g*8] == i_now[g*8+6:g*8];
        end
    endgenerate
    logic alm_hit_ff, alm_now;
    assign alm_now = |fld_used && &fld_ok;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) alm_hit_ff <= 1'b0;
        else if (i_ce) alm_hit_ff <= alm_now;
    end
    logic alm_set;
    assign alm_set = i_ce && alm_now && !alm_hit_ff;
    // Watchdog.
    logic [5:0] wd_cnt_ff;
    logic wd_set, wd_tick;
    assign wd_tick = tick && &div_ff[`RTCOCW_TAP_32:0];
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            wd_ff <= 8'h00;
        end else if (i_ce && wr_at(i_req, `RTCOCW_REG_WD_CTRL)) begin
            wd_ff[`RTCOCW_WD_LOCK] <= i_req.data[`RTCOCW_WD_LOCK];
            if (!i_req.data[`RTCOCW_WD_LOCK]) wd_ff[5:0] <= i_req.data[5:0];
        end
    end
    logic wd_pu_ff;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_ff <= 6'h0;
            wd_pu_ff  <= 1'b1;
        end else if (i_ce) begin
            wd_pu_ff <= 1'b0;
            if (wd_pu_ff || wr_at(i_req, `RTCOCW_REG_WD_CTRL) && i_req.data[`RTCOCW_WD_STROBE])
                wd_cnt_ff <= wd_ff[5:0];
            else if (wd_tick && wd_cnt_ff != 6'h0) wd_cnt_ff <= wd_cnt_ff - 6'h1;
        end
    end
    assign wd_set = i_ce && wd_tick && wd_cnt_ff == 6'h1 && wd_ff[5:0] != 6'h0;
    // Flags register: hardware set wins over the read clear.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= 8'h00;
        end else if (i_ce) begin
            if (rd_flags) begin
                flags_ff[`RTCOCW_FLG_ALARM] <= 1'b0;
                flags_ff[`RTCOCW_FLG_WD]    <= 1'b0;
            end
            if (wr_flags) begin
                flags_ff[`RTCOCW_FLG_WR_UNLOCK] <= i_req.data[`RTCOCW_FLG_WR_UNLOCK];
                if (flags_ff[`RTCOCW_FLG_WR_UNLOCK]) begin
                    flags_ff[`RTCOCW_FLG_CAL_OUT]  <= i_req.data[`RTCOCW_FLG_CAL_OUT];
                    flags_ff[`RTCOCW_FLG_OSC_FAIL] <= i_req.data[`RTCOCW_FLG_OSC_FAIL];
                end
            end
            if (fail_set) flags_ff[`RTCOCW_FLG_OSC_FAIL] <= 1'b1;
            if (alm_set)  flags_ff[`RTCOCW_FLG_ALARM]    <= 1'b1;
            if (wd_set)   flags_ff[`RTCOCW_FLG_WD]       <= 1'b1;
        end
    end
    // Read data.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_ce && i_req.rd) begin
            unique case (i_req.addr)
                `RTCOCW_REG_FLAGS:    o_rdata <= flags_ff;
                `RTCOCW_REG_ALM_SEC:  o_rdata <= alm_sh_ff.sec;
                `RTCOCW_REG_ALM_MIN:  o_rdata <= alm_sh_ff.min;
                `RTCOCW_REG_ALM_HOUR: o_rdata <= alm_sh_ff.hour;
                `RTCOCW_REG_ALM_DATE: o_rdata <= alm_sh_ff.date;
                `RTCOCW_REG_IRQ_CTRL: o_rdata <= irq_ff;
                `RTCOCW_REG_WD_CTRL:  o_rdata <= {1'b0, wd_ff[6:0]};
                `RTCOCW_REG_TRIM:     o_rdata <= trim_ff;
                default:              o_rdata <= 8'h00;
            endcase
        end
    end
    // Interrupt pin source.
    rtcocw_sq_e sq_sel;
    logic sq_wave, irq_act;
    assign sq_sel = rtcocw_sq_e'({irq_ff[`RTCOCW_IRQ_SQ_HI], irq_ff[`RTCOCW_IRQ_SQ_LO]});
    always_comb begin
        unique case (sq_sel)
            RTCOCW_SQ_1HZ:    sq_wave = div_ff[`RTCOCW_TAP_1];
            RTCOCW_SQ_512HZ:  sq_wave = div_ff[`RTCOCW_TAP_512];
            RTCOCW_SQ_4096HZ: sq_wave = div_ff[`RTCOCW_TAP_4096];
            // The full-rate wave is the oscillator tick itself, so its duty follows the tick.
            RTCOCW_SQ_32KHZ:  sq_wave = tick;
        endcase
    end
    assign irq_act = flags_ff[`RTCOCW_FLG_ALARM] && irq_ff[`RTCOCW_IRQ_ALM_EN]
                     || flags_ff[`RTCOCW_FLG_WD] && irq_ff[`RTCOCW_IRQ_WD_EN];
    always_comb begin
        o_int_oe    = 1'b0;
        o_int_level = 1'b0;
        if (flags_ff[`RTCOCW_FLG_CAL_OUT]) begin
            o_int_oe    = 1'b1;
            o_int_level = div_ff[`RTCOCW_TAP_512];
        end else if (irq_ff[`RTCOCW_IRQ_SQ_EN]) begin
            o_int_oe    = !i_on_backup;
            o_int_level = sq_wave;
        end else if (irq_act && !i_on_backup) begin
            o_int_oe    = 1'b1;
            o_int_level = 1'b0;
        end
    end
    // Checks.
    wd_zero_off_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        wd_ff[5:0] == 6'h0 && !flags_ff[`RTCOCW_FLG_WD] |=> !flags_ff[`RTCOCW_FLG_WD])
        else $error("watchdog fired while disabled");
    rd_clear_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        rd_flags && !alm_set && !wd_set |=>
        !flags_ff[`RTCOCW_FLG_ALARM] && !flags_ff[`RTCOCW_FLG_WD])
        else $error("flags not cleared by read");
    alm_set_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        alm_set |=> flags_ff[`RTCOCW_FLG_ALARM]) else $error("alarm flag not set");
    alm_never_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        &{alm_ff.sec[7], alm_ff.min[7], alm_ff.hour[7], alm_ff.date[7]}
        && !flags_ff[`RTCOCW_FLG_ALARM] |=> !flags_ff[`RTCOCW_FLG_ALARM])
        else $error("alarm fired with all fields masked");
    lock_keep_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        wr_flags && !flags_ff[`RTCOCW_FLG_WR_UNLOCK] && !fail_set |=>
        $stable(flags_ff[`RTCOCW_FLG_OSC_FAIL]) && $stable(flags_ff[`RTCOCW_FLG_CAL_OUT]))
        else $error("flag bits written while locked");
    cal_pin_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        flags_ff[`RTCOCW_FLG_CAL_OUT] |-> o_int_oe && o_int_level == div_ff[`RTCOCW_TAP_512])
        else $error("calibration output not on pin");
    wd_lock_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        i_ce && wr_at(i_req, `RTCOCW_REG_WD_CTRL) && i_req.data[`RTCOCW_WD_LOCK] |=>
        $stable(wd_ff[5:0])) else $error("timeout changed while locked");
    wd_freeze_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        !osc_en && !(i_ce && i_req.wr) |=> $stable(wd_cnt_ff))
        else $error("watchdog ran without oscillator");
    osc_run_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        i_ce && wr_at(i_req, `RTCOCW_REG_TRIM) |=>
        o_osc_run == !$past(i_req.data[`RTCOCW_TRIM_OSC_DIS]))
        else $error("oscillator enable wrong");
    osc_fail_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        fail_set |=> flags_ff[`RTCOCW_FLG_OSC_FAIL]) else $error("oscillator fail flag not set");
    wd_reload_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        i_ce && wr_at(i_req, `RTCOCW_REG_WD_CTRL) && i_req.data[`RTCOCW_WD_STROBE] |=>
        wd_cnt_ff == $past(wd_ff[5:0])) else $error("watchdog not reloaded by strobe");
    sq_backup_a: assert property (@(posedge i_clock) disable iff (!rst_n)
        !flags_ff[`RTCOCW_FLG_CAL_OUT] && i_on_backup |-> !o_int_oe)
        else $error("pin driven on backup power");
endmodule : rtcocw_top

// ---- verification/rtcocw_host.sv ----
// Host side model that issues single-cycle register requests to the RTC block.
`timescale 1ns/1ns
module rtcocw_host (
    input  wire logic               i_clock,
    input  wire logic [7:0]         i_rdata,
    output rtcocw_pkg::rtcocw_req_s o_req
);
    import rtcocw_pkg::*;
    initial o_req = '0;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge i_clock);
        o_req = '0;
    endtask : wr
    // Read data is taken two full cycles after the request edge.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge i_clock);
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge i_clock);
        o_req = '0;
        @(negedge i_clock);
        d = i_rdata;
    endtask : rd
    // The closing write keeps the data bits so the unlock fall does not clear them.
    task automatic flags_wr(input logic [7:0] d);
        wr(4'h0, 8'h02);
        wr(4'h0, d | 8'h02);
        wr(4'h0, d);
    endtask : flags_wr
    task automatic alarm_wr(input logic [7:0] s);
        wr(4'h0, 8'h02);
        wr(4'h2, s & 8'h7f);
        wr(4'h3, 8'h80);
        wr(4'h4, 8'h80);
        wr(4'h5, 8'h80);
    endtask : alarm_wr
endmodule : rtcocw_host

// ---- verification/test_rtc_osc_cal_alarm_watchdog.sv ----
// Self-checking testbench for the RTC oscillator, trim, alarm and watchdog block.
`timescale 1ns/1ns
module test_rtc_osc_cal_alarm_watchdog;
    import rtcocw_pkg::*;
    logic                clk;
    logic                nrst;
    logic                ten;
    logic                ce;
    logic [14:0]         adj;
    logic                tick;
    logic                bk;
    logic [1:0]          cyc;
    rtcocw_time_s        now;
    rtcocw_req_s         req;
    logic [7:0]          rdata;
    logic                o_osc_run;
    logic                o_osc_stable;
    logic                o_base_reload;
    logic                o_int_level;
    logic                o_int_oe;
    logic                o_trim_sign;
    int                  n_mismatch = 0;
    int                  total_checks = 0;
    int                  nrel = 0;
    int                  fq[4] = '{1, 512, 4096, 32768};
    // Open-drain pin with pull-up.
    wire                 pin = o_int_oe ? o_int_level : 1'b1;
    rtcocw_host host (.i_clock(clk), .i_rdata(rdata), .o_req(req));
    rtcocw_top #(.OSC_FAIL_CYC(20), .OSC_START_CYC(30)) dut (
        .i_clock(clk), .i_nrst(nrst), .i_ce(ce), .i_req(req), .i_osc_tick(tick),
        .i_on_backup(bk), .i_now(now), .o_rdata(rdata), .o_osc_run(o_osc_run),
        .o_osc_stable(o_osc_stable), .o_base_reload(o_base_reload), .o_trim_adjust(adj),
        .o_trim_sign(o_trim_sign), .o_int_level(o_int_level), .o_int_oe(o_int_oe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Oscillator tick every fourth clock, so one oscillator period is 4 clocks.
    always @(negedge clk) begin
        cyc <= cyc + 2'h1;
        tick <= ten && (cyc == 2'h3);
    end
    always @(posedge clk) if (o_base_reload === 1'b1) nrel++;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask : rdchk
    task automatic rise(output int n);
        logic q;
        q = pin;
        for (n = 1; n < 2000; n++) begin
            @(negedge clk);
            if (q === 1'b0 && pin === 1'b1) break;
            q = pin;
        end
    endtask : rise
    task automatic per(output int p);
        int a;
        int b;
        rise(a);
        rise(b);
        p = (a < 2000 && b < 2000) ? b : -1;
    endtask : per
    task automatic wait_int(output int n);
        for (n = 0; n < 20000 && o_int_oe !== 1'b1; n++) @(negedge clk);
    endtask : wait_int
    task automatic results;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    initial begin
        #(80000 * 20);
        n_mismatch++;
        results();
    end
    initial begin
        int         p;
        int         n;
        logic [7:0] s;
        logic [7:0] tr;
        void'($urandom(87576));
        {nrst, ten, bk, cyc, tick} = '0;
        ce = 1'b1;
        now = '0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (40) @(negedge clk);
        chk(nrel, 1);
        chk(o_osc_run, 1);
        rdchk(4'h8, 8'h00);
        rdchk(4'h0, 8'h20);
        ten = 1'b1;
        host.flags_wr(8'h00);
        rdchk(4'h0, 8'h00);
        host.wr(4'h0, 8'h04);
        per(p);
        chk(p, -1);
        tr = {2'b00, 1'($urandom), 5'($urandom)};
        host.wr(4'h8, tr);
        rdchk(4'h8, tr);
        chk(o_trim_sign, tr[5]);
        chk(adj, (tr[4:0] == 5'h00) ? 16'h0000 : (tr[5] ? 16'h0100 : 16'h0080));
        host.wr(4'h6, 8'h42);
        host.flags_wr(8'h04);
        per(p);
        chk(p, 256);
        // Half a test period with the enable low: a running divider would invert the pin.
        ce = 1'b0;
        s = {7'h00, pin};
        repeat (128) @(negedge clk);
        chk(pin, s[0]);
        ce = 1'b1;
        host.flags_wr(8'h00);
        for (int c = 0; c < 4; c++) begin
            host.wr(4'h6, 8'h40 | 8'(c));
            per(p);
            chk(p, (c == 0) ? -1 : 131072 / fq[c]);
        end
        bk = 1'b1;
        per(p);
        chk(p, -1);
        bk = 1'b0;
        host.wr(4'h6, 8'h20);
        now = 32'h12345678;
        repeat (3) @(negedge clk);
        chk(o_int_oe, 0);
        s = {1'b0, 3'($urandom % 6), 4'($urandom % 9)};
        host.alarm_wr(s);
        now.sec = s;
        repeat (3) @(negedge clk);
        chk(o_int_oe, 0);
        now.sec = s ^ 8'h01;
        host.wr(4'h0, 8'h00);
        repeat (3) @(negedge clk);
        now.sec = s;
        repeat (3) @(negedge clk);
        chk({o_int_oe, o_int_level}, 2'b10);
        rdchk(4'h0, 8'h40);
        chk(o_int_oe, 0);
        host.wr(4'h6, 8'h80);
        host.wr(4'h7, 8'h02);
        host.wr(4'h7, 8'hc5);
        rdchk(4'h7, 8'h42);
        wait_int(n);
        chk(n > 4000 && n < 8400, 1);
        rdchk(4'h0, 8'h80);
        chk(o_int_oe, 0);
        host.wr(4'h7, 8'h00);
        host.wr(4'h7, 8'h80);
        repeat (9000) @(negedge clk);
        chk(o_int_oe, 0);
        host.wr(4'h7, 8'h01);
        host.wr(4'h8, 8'h80);
        chk(o_osc_run, 0);
        host.wr(4'h7, 8'hc1);
        repeat (9000) @(negedge clk);
        chk(o_int_oe, 0);
        host.wr(4'h8, 8'h00);
        for (n = 0; n < 40 && o_osc_stable !== 1'b1; n++) @(negedge clk);
        chk(o_osc_stable, 1);
        wait_int(n);
        chk(n < 9000, 1);
        results();
    end
endmodule : test_rtc_osc_cal_alarm_watchdog
